// ---- verilog/crf_top.sv ----
/*
 * CPU control register file: the registers reached by the control-move
 * instruction on the side-B shift unit, with their side effects.
 * Assumes the pipeline drives one control-move request per cycle in the
 * first execute phase and signals interrupt entry, returns and saturation.
 */
`timescale 1ns/1ps
module crf_top
    import crf_pkg::*;
#(
    parameter logic [7:0] CPU_ID = 8'h5A,  // Arbitrary value
    parameter logic [7:0] REV_ID = 8'h01,  // Arbitrary value
    parameter logic       ENDIAN = 1'b0    // Arbitrary value
) (
    input  wire logic         i_sys_clk,   // CPU clock, 25 MHz
    input  wire logic         i_rst_b,     // Async reset, active low
    input  wire logic         i_ce,        // Clock enable, freezes state
    input  wire crf_mv_req_t  i_mv,        // Control-move request
    output logic [31:0]       o_mv_rdata,  // Read data, next cycle
    output logic              o_mv_rvalid, // Read data valid pulse
    input  wire logic [31:0]  i_irq_pin,   // Maskable irq events
    input  wire logic         i_irq_take,  // Irq processing begins
    input  wire logic [4:0]   i_irq_num,   // Irq being taken
    input  wire logic         i_ret_irq,   // Return-from-irq branch
    input  wire logic         i_ret_nmi,   // Return-from-nmi branch
    input  wire logic         i_sat_wr,    // Saturated result written
    input  wire logic [31:0]  i_pc_e1,     // Execute-phase PC
    output logic              o_gie,       // Global irq enable
    output logic              o_nonmaskable_irq_enable,      // Nonmaskable irq enable
    output logic [31:0]       o_ifr,       // Pending flags
    output logic [31:0]       o_irq_req,   // Pending and enabled
    output logic [31:0]       o_vtb,       // Vector table base
    output logic [31:0]       o_ira,       // Irq return address
    output logic [31:0]       o_nra,       // Nmi return address
    output crf_ptr_cfg_t      o_ptr [CRF_PTRS] // Pointer modes A4..B7
);

    logic [31:0] amr_r;
    logic [31:0] csr_r;
    logic [31:0] ien_r;
    logic [31:0] vtb_r;
    logic [31:0] ira_r;
    logic [31:0] nra_r;
    logic [31:0] ifr_r;
    logic [31:0] set_pend_r;
    logic [31:0] clr_pend_r;
    logic        sat_dly_r;
    logic [31:0] rdata_r;
    logic        rvalid_r;

    // Decode: writes to read-only addresses match nothing
    wire         w_wr      = i_mv.valid & i_mv.wr;
    wire         w_rd      = i_mv.valid & ~i_mv.wr;
    wire         w_amr_wr  = w_wr & (i_mv.addr == CRF_A_AMR);
    wire         w_csr_wr  = w_wr & (i_mv.addr == CRF_A_CSR);
    wire         w_set_wr  = w_wr & (i_mv.addr == CRF_A_FLG);
    wire         w_clr_wr  = w_wr & (i_mv.addr == CRF_A_CLR);
    wire         w_ien_wr  = w_wr & (i_mv.addr == CRF_A_IEN);
    wire         w_vtb_wr  = w_wr & (i_mv.addr == CRF_A_VTB);
    wire         w_ira_wr  = w_wr & (i_mv.addr == CRF_A_IRA);
    wire         w_nra_wr  = w_wr & (i_mv.addr == CRF_A_NRA);

    wire  [31:0] w_csr_rd  = {CPU_ID, REV_ID, csr_r[15:CRF_SAT], ENDIAN,
                              csr_r[CRF_EN-1:0]};
    wire  [31:0] w_ien_rd  = ien_r | CRF_IEN_ONE;

    // Read mux; write-only and unmapped addresses return zero
    wire  [31:0] w_rd_val  =
        (i_mv.addr == CRF_A_AMR) ? amr_r    :
        (i_mv.addr == CRF_A_CSR) ? w_csr_rd :
        (i_mv.addr == CRF_A_FLG) ? ifr_r    :
        (i_mv.addr == CRF_A_IEN) ? w_ien_rd :
        (i_mv.addr == CRF_A_VTB) ? vtb_r    :
        (i_mv.addr == CRF_A_IRA) ? ira_r    :
        (i_mv.addr == CRF_A_NRA) ? nra_r    :
        (i_mv.addr == CRF_A_PCE) ? i_pc_e1  :
        CRF_ZERO;

    // Pending flags: pins beat everything, set beats clear
    wire  [31:0] w_take    = i_irq_take ? (CRF_ONE << i_irq_num) : CRF_ZERO;
    wire  [31:0] w_pins    = i_irq_pin & CRF_IRQ_MSK;
    wire  [31:0] w_clr_eff = clr_pend_r & ~set_pend_r;
    wire  [31:0] ifr_nxt   = ((((ifr_r | set_pend_r) & ~w_clr_eff)
                             & ~w_take) | w_pins) & CRF_IRQ_MSK;

    // Global enable and its saved copy
    wire         gie_nxt   = i_irq_take ? 1'b0 :
                             i_ret_irq  ? csr_r[CRF_PGIE] :
                             w_csr_wr   ? i_mv.data[CRF_GIE] :
                             csr_r[CRF_GIE];
    wire         pgie_nxt  = i_irq_take ? csr_r[CRF_GIE] :
                             w_csr_wr   ? i_mv.data[CRF_PGIE] :
                             csr_r[CRF_PGIE];
    // Clipped flag: a late set still wins over a same-cycle clear
    wire         sat_nxt   = sat_dly_r |
                             (csr_r[CRF_SAT] &
                              (~w_csr_wr | i_mv.data[CRF_SAT]));
    wire  [31:0] w_csr_fld = w_csr_wr ? (i_mv.data & CRF_CSR_WMSK)
                                      : (csr_r & CRF_CSR_WMSK);
    wire  [31:0] csr_nxt   = {w_csr_fld[31:CRF_SAT+1], sat_nxt,
                              w_csr_fld[CRF_SAT-1:CRF_PGIE+1],
                              pgie_nxt, gie_nxt};

    wire         nonmaskable_irq_enable_nxt  = i_ret_nmi ? 1'b1 :
                             w_ien_wr  ? i_mv.data[CRF_NONMASKABLE_IRQ_ENABLE] :
                             ien_r[CRF_NONMASKABLE_IRQ_ENABLE];
    wire  [31:0] w_ien_fld = w_ien_wr ? (i_mv.data & CRF_IEN_WMSK)
                                      : ien_r;
    wire  [31:0] ien_nxt   = {w_ien_fld[31:CRF_NONMASKABLE_IRQ_ENABLE+1], nonmaskable_irq_enable_nxt,
                              1'b0};

    // Single-cycle access in the first execute phase
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            amr_r      <= CRF_AMR_RST;
            csr_r      <= CRF_CSR_RST;
            ien_r      <= CRF_ZERO;
            vtb_r      <= CRF_ZERO;
            ira_r      <= CRF_ZERO;
            nra_r      <= CRF_ZERO;
            ifr_r      <= CRF_ZERO;
            set_pend_r <= CRF_ZERO;
            clr_pend_r <= CRF_ZERO;
            sat_dly_r  <= 1'b0;
            rdata_r    <= CRF_ZERO;
            rvalid_r   <= 1'b0;
        end else if (i_ce) begin
            if (w_amr_wr) begin
                amr_r <= i_mv.data & CRF_AMR_WMSK;
            end
            if (w_vtb_wr) begin
                vtb_r <= i_mv.data;
            end
            if (w_ira_wr) begin
                ira_r <= i_mv.data;
            end
            if (w_nra_wr) begin
                nra_r <= i_mv.data;
            end
            csr_r      <= csr_nxt;
            ien_r      <= ien_nxt;
            ifr_r      <= ifr_nxt;
            // Staged so the flags move one clock after the write
            set_pend_r <= w_set_wr ? (i_mv.data & CRF_IRQ_MSK) : CRF_ZERO;
            clr_pend_r <= w_clr_wr ? (i_mv.data & CRF_IRQ_MSK) : CRF_ZERO;
            // Caller pulses at the result write, E2 end for multiply
            sat_dly_r  <= i_sat_wr;
            rvalid_r   <= w_rd;
            if (w_rd) begin
                rdata_r <= w_rd_val;
            end
        end
    end

    assign o_mv_rdata  = rdata_r;
    assign o_mv_rvalid = rvalid_r;
    assign o_gie       = csr_r[CRF_GIE];
    assign o_nonmaskable_irq_enable      = ien_r[CRF_NONMASKABLE_IRQ_ENABLE];
    assign o_ifr       = ifr_r;
    assign o_irq_req   = ifr_r & ien_r & CRF_IRQ_MSK;
    assign o_vtb       = vtb_r;
    assign o_ira       = ira_r;
    assign o_nra       = nra_r;

    // Pointer decode, index 0..3 = A4..A7, 4..7 = B4..B7
    wire [CRF_BK_W-1:0] w_bk0 = amr_r[CRF_BK0_LSB +: CRF_BK_W];
    wire [CRF_BK_W-1:0] w_bk1 = amr_r[CRF_BK1_LSB +: CRF_BK_W];

    genvar gi;
    generate
        for (gi = 0; gi < CRF_PTRS; gi++) begin : g_ptr
            wire [1:0] w_mode = amr_r[gi*CRF_MODE_W +: CRF_MODE_W];
            wire [4:0] w_bk   = (w_mode == CRF_MODE_C1) ? w_bk1 : w_bk0;
            // Reserved code 3 falls back to linear
            wire       w_circ = ((w_mode == CRF_MODE_C0) ||
                                 (w_mode == CRF_MODE_C1)) &&
                                (w_bk != CRF_BK_LIN);
            assign o_ptr[gi].circ      = w_circ;
            assign o_ptr[gi].size_log2 = {1'b0, w_bk} + CRF_BK_ADD1;

            a_bk_all_ones: assert property (@(posedge i_sys_clk)
                disable iff (!i_rst_b)
                (w_bk == CRF_BK_LIN) |-> !o_ptr[gi].circ)
                else $error("circular mode active with all-ones block size");

            // Reserved code must never open a circular window
            a_mode_reserved: assert property (@(posedge i_sys_clk)
                disable iff (!i_rst_b)
                (w_mode == ~CRF_MODE_LIN) |-> !o_ptr[gi].circ)
                else $error("reserved mode code selected circular addressing");
        end
    endgenerate

    a_amr_reserved: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        amr_r[31:26] == 6'h00)
        else $error("addressing-mode reserved bits not zero");

    a_amr_readback: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_AMR)
            |=> o_mv_rvalid && o_mv_rdata == $past(amr_r))
        else $error("addressing-mode read returned wrong data");

    a_flag_set_late: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_set_wr) ##1 i_ce
            |=> (ifr_r & $past(i_mv.data, 2) & CRF_IRQ_MSK)
                == ($past(i_mv.data, 2) & CRF_IRQ_MSK))
        else $error("flag-set write not applied one clock later");

    a_flag_clr_late: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_clr_wr && i_irq_pin == CRF_ZERO && set_pend_r == CRF_ZERO)
            ##1 (i_ce && i_irq_pin == CRF_ZERO && set_pend_r == CRF_ZERO)
            |=> (ifr_r & $past(i_mv.data, 2) & CRF_IRQ_MSK) == CRF_ZERO)
        else $error("flag-clear write not applied one clock later");

    a_pin_sets_flag: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        i_ce |=> (ifr_r & $past(w_pins)) == $past(w_pins))
        else $error("interrupt pin event lost");

    a_entry_gie: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && i_irq_take)
            |=> !o_gie && csr_r[CRF_PGIE] == $past(csr_r[CRF_GIE]))
        else $error("interrupt entry did not save and clear global enable");

    a_ret_gie: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && i_ret_irq && !i_irq_take)
            |=> o_gie == $past(csr_r[CRF_PGIE]))
        else $error("irq return did not restore global enable");

    a_ret_nonmaskable_irq_enable: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && i_ret_nmi) |=> o_nonmaskable_irq_enable)
        else $error("nmi return did not set nonmaskable enable");

    a_sat_timing: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && i_sat_wr && !sat_dly_r && !csr_r[CRF_SAT])
            |=> !csr_r[CRF_SAT] ##1 (!i_ce || csr_r[CRF_SAT]))
        else $error("clipped flag not set exactly one cycle after result");

    a_pc_read_only: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_wr && (i_mv.addr == CRF_A_PCE || i_mv.addr == CRF_A_FLG))
            |=> $stable(amr_r) && $stable(vtb_r) && $stable(nra_r))
        else $error("write to non-storing address changed a register");

    // Read path: one pulse per taken read, data of the named register
    a_rd_pulse: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        i_ce
            |=> o_mv_rvalid == $past(w_rd))
        else $error("read valid pulse does not follow the move");

    a_flag_read: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_FLG)
            |=> o_mv_rdata == $past(ifr_r))
        else $error("pending flag read returned wrong data");

    a_ien_read: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_IEN)
            |=> o_mv_rdata == ($past(ien_r) | CRF_IEN_ONE))
        else $error("interrupt enable read returned wrong data");

    a_csr_read: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_CSR)
            |=> o_mv_rdata[CRF_EN] == ENDIAN && o_mv_rdata[CRF_SAT] == $past(csr_r[CRF_SAT]))
        else $error("control status read returned wrong data");

    a_pc_read: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_PCE)
            |=> o_mv_rdata == $past(i_pc_e1))
        else $error("execute-phase pc read returned wrong data");

    // Write-only address reads as zero rather than leaking a register
    a_wo_read_zero: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_rd && i_mv.addr == CRF_A_CLR)
            |=> o_mv_rdata == CRF_ZERO)
        else $error("flag-clear read returned nonzero data");

    a_vtb_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_vtb_wr)
            |=> o_vtb == $past(i_mv.data))
        else $error("vector base write not stored");

    a_ira_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_ira_wr)
            |=> o_ira == $past(i_mv.data))
        else $error("irq return address write not stored");

    a_nra_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_nra_wr)
            |=> o_nra == $past(i_mv.data))
        else $error("nmi return address write not stored");

    a_set_over_clr: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && !i_irq_take && (set_pend_r & clr_pend_r) != CRF_ZERO)
            |=> (ifr_r & $past(set_pend_r & clr_pend_r)) == $past(set_pend_r & clr_pend_r))
        else $error("same-cycle clear beat a flag set");

    // No flag may rise without a set write or a pin event behind it
    a_flag_cause: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && set_pend_r == CRF_ZERO && w_pins == CRF_ZERO)
            |=> (ifr_r & ~$past(ifr_r)) == CRF_ZERO)
        else $error("pending flag rose without a cause");

    a_take_clears: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && i_irq_take)
            |=> (ifr_r & $past(w_take & ~w_pins)) == CRF_ZERO)
        else $error("interrupt entry left its flag pending");

    a_gie_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_csr_wr && !i_irq_take && !i_ret_irq)
            |=> o_gie == $past(i_mv.data[CRF_GIE]))
        else $error("global enable write not stored");

    a_nonmaskable_irq_enable_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_ien_wr && !i_ret_nmi)
            |=> o_nonmaskable_irq_enable == $past(i_mv.data[CRF_NONMASKABLE_IRQ_ENABLE]))
        else $error("nonmaskable enable write not stored");

    a_sat_clear: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_ce && w_csr_wr && !i_mv.data[CRF_SAT] && !sat_dly_r)
            |=> !csr_r[CRF_SAT])
        else $error("clipped flag not cleared by a zero write");

    a_ce_freeze: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        !i_ce
            |=> $stable(amr_r) && $stable(csr_r) && $stable(ifr_r) && $stable(ien_r) && $stable(o_mv_rvalid))
        else $error("state moved while clock enable was low");

endmodule

// ---- verilog/crf_pkg.sv ----
/*
 * Constants and carrier types for the CPU control register file.
 * Assumes a single 25 MHz CPU clock domain; all users import crf_pkg::*.
 */
package crf_pkg;

    // Control addresses decoded by the control-move path
    localparam logic [4:0]  CRF_A_AMR  = 5'h00;
    localparam logic [4:0]  CRF_A_CSR  = 5'h01;
    localparam logic [4:0]  CRF_A_FLG  = 5'h02;
    localparam logic [4:0]  CRF_A_CLR  = 5'h03;
    localparam logic [4:0]  CRF_A_IEN  = 5'h04;
    localparam logic [4:0]  CRF_A_VTB  = 5'h05;
    localparam logic [4:0]  CRF_A_IRA  = 5'h06;
    localparam logic [4:0]  CRF_A_NRA  = 5'h07;
    localparam logic [4:0]  CRF_A_PCE  = 5'h10;

    // Addressing-mode register layout
    localparam int          CRF_PTRS     = 8;
    localparam int          CRF_MODE_W   = 2;
    localparam int          CRF_BK_W     = 5;
    localparam int          CRF_BK0_LSB  = 16;
    localparam int          CRF_BK1_LSB  = 21;
    localparam logic [31:0] CRF_AMR_WMSK = 32'h03FF_FFFF;
    localparam logic [31:0] CRF_AMR_RST  = 32'h0000_0000;
    localparam logic [1:0]  CRF_MODE_LIN = 2'h0;
    localparam logic [1:0]  CRF_MODE_C0  = 2'h1;
    localparam logic [1:0]  CRF_MODE_C1  = 2'h2;
    localparam logic [4:0]  CRF_BK_LIN   = 5'h1F;

    // Control status register layout
    localparam int          CRF_GIE      = 0;
    localparam int          CRF_PGIE     = 1;
    localparam int          CRF_EN       = 8;
    localparam int          CRF_SAT      = 9;
    localparam logic [31:0] CRF_CSR_WMSK = 32'h0000_FCFF;
    localparam logic [31:0] CRF_CSR_RST  = 32'h0000_0000;

    // Interrupt flag and enable layout
    localparam logic [31:0] CRF_IRQ_MSK  = 32'h0000_FFF0;
    localparam logic [31:0] CRF_IEN_WMSK = 32'h0000_FFF2;
    localparam logic [31:0] CRF_IEN_ONE  = 32'h0000_0001;
    localparam int          CRF_NONMASKABLE_IRQ_ENABLE     = 1;
    localparam logic [31:0] CRF_ZERO     = 32'h0000_0000;
    localparam logic [31:0] CRF_ONE      = 32'h0000_0001;
    localparam logic [5:0]  CRF_BK_ADD1  = 6'h01;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [4:0]  addr;
        logic [31:0] data;
    } crf_mv_req_t;

    typedef struct packed {
        logic       circ;
        logic [5:0] size_log2;
    } crf_ptr_cfg_t;

endpackage

// ---- test/crf_mover.sv ----
/*
 * Side-B shift unit model: issues one control move at a time into the
 * control register file. Assumes callers are in a process on the bench clock.
 */
`timescale 1ns/1ps
module crf_mover
    import crf_pkg::*;
(
    input  wire logic        i_sys_clk, // CPU clock
    input  wire logic        i_rvalid,  // Read data valid
    input  wire logic [31:0] i_rdata,   // Read data
    output crf_mv_req_t      o_mv       // Move request
);
    initial o_mv = '0;

    // One move per call; a gap cycle follows so valid never toggles twice
    task automatic move(input logic wr, input logic [4:0] addr, input logic [31:0] data,
                        output logic [31:0] rd);
        @(negedge i_sys_clk);
        o_mv = '{1'b1, wr, addr, data};
        @(negedge i_sys_clk);
        rd = (!wr && i_rvalid === 1'b1) ? i_rdata : 'x;
        o_mv = '{1'b0, wr, addr, ~data}; // Stale bus never repeats the last word
    endtask
endmodule

// ---- test/tb.sv ----
/*
 * Self-checking bench for the control register file.
 * Assumes crf_pkg and crf_top; moves come from the crf_mover model.
 */
`timescale 1ns/1ps
module tb;
    import crf_pkg::*;
    localparam logic [7:0] ID_V  = 8'h3C; // Arbitrary value
    localparam logic [7:0] REV_V = 8'h02; // Arbitrary value
    logic         sys_clk = 1'b0;
    logic         rst_b   = 1'b0;
    logic         take    = 1'b0;
    logic         ret_i   = 1'b0;
    logic         ret_n   = 1'b0;
    logic         clipped_result_flag     = 1'b0;
    logic         ce      = 1'b1;
    logic         rvalid, global_irq_enable, nonmaskable_irq_enable;
    logic [4:0]   a;
    logic [31:0]  pin = '0;
    logic [31:0]  pc  = '0;
    logic [31:0]  rdata, pending_interrupt_flags, irq_req, vtb, ira, nra, d, e, rd;
    crf_mv_req_t  mv;
    crf_ptr_cfg_t ptr [CRF_PTRS];
    integer       bad_count = 0;
    integer       tests_run = 0;
    integer       seed = 24;
    integer       k, p;
    logic [4:0]   addrs [6] = '{CRF_A_AMR, CRF_A_CSR, CRF_A_IEN, CRF_A_VTB, CRF_A_IRA, CRF_A_NRA};
    logic [31:0]  corner [4] = '{32'hFFFF_FFFF, 32'h001F_5555, 32'h03E0_AAAA, 32'h0000_5555};

    always #20 sys_clk = ~sys_clk;

    crf_top #(.CPU_ID(ID_V), .REV_ID(REV_V), .ENDIAN(1'b0)) uut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ce(ce), .i_mv(mv), .o_mv_rdata(rdata),
        .o_mv_rvalid(rvalid), .i_irq_pin(pin), .i_irq_take(take), .i_irq_num(5'h07),
        .i_ret_irq(ret_i), .i_ret_nmi(ret_n), .i_sat_wr(clipped_result_flag), .i_pc_e1(pc), .o_gie(global_irq_enable),
        .o_nonmaskable_irq_enable(nonmaskable_irq_enable), .o_ifr(pending_interrupt_flags), .o_irq_req(irq_req), .o_vtb(vtb), .o_ira(ira),
        .o_nra(nra), .o_ptr(ptr));

    crf_mover mover (.i_sys_clk(sys_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_mv(mv));

    function automatic logic [31:0] exp_rd(input logic [4:0] ad, input logic [31:0] v);
        case (ad)
            CRF_A_AMR: return v & CRF_AMR_WMSK;
            CRF_A_CSR: return {ID_V, REV_V, v[15:10], 2'b00, v[7:0]};
            CRF_A_IEN: return (v & CRF_IEN_WMSK) | CRF_IEN_ONE;
            default:   return v;
        endcase
    endfunction

    function automatic logic [6:0] exp_ptr(input int n, input logic [31:0] v);
        logic [1:0] m;
        logic [4:0] bk;
        m  = v[2*n +: 2];
        bk = (m == CRF_MODE_C1) ? v[25:21] : v[20:16];
        return {(m == CRF_MODE_C0 || m == CRF_MODE_C1) && bk != CRF_BK_LIN, {1'b0, bk} + 6'h01};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask

    task automatic check_ptrs(input logic [31:0] v);
        for (p = 0; p < CRF_PTRS; p++) begin
            check("ptr", {25'h0, ptr[p]}, {25'h0, exp_ptr(p, v)});
        end
    endtask

    initial begin
        #(40 * 4000);
        bad_count++;
        report_and_stop;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk) rst_b = 1'b1;
        check_ptrs('0);
        for (k = 0; k < 6; k++) begin
            mover.move(1'b0, addrs[k], '0, rd);
            check("reset", rd, exp_rd(addrs[k], '0));
        end
        // Corners first: reserved mode, block-size all ones, smallest block
        for (k = 0; k < 28; k++) begin
            a = (k < 4) ? CRF_A_AMR : addrs[k % 6];
            d = (k < 4) ? corner[k] : $random(seed);
            mover.move(1'b1, a, d, rd);
            mover.move(1'b0, a, '0, rd);
            check("rw", rd, exp_rd(a, d));
            if (a == CRF_A_AMR) check_ptrs(d);
            if (a == CRF_A_VTB) check("vtb", vtb, d);
            if (a == CRF_A_IRA) check("ira", ira, d);
            if (a == CRF_A_NRA) check("nra", nra, d);
        end
        // A write while the clock enable is low must leave no trace
        e = $random(seed);
        mover.move(1'b1, CRF_A_VTB, e, rd);
        ce = 1'b0;
        mover.move(1'b1, CRF_A_VTB, ~e, rd);
        ce = 1'b1;
        check("ce_hold", vtb, e);
        pc = $random(seed);
        mover.move(1'b0, CRF_A_PCE, '0, rd);
        check("pc", rd, pc);
        mover.move(1'b1, CRF_A_PCE, ~pc, rd);
        mover.move(1'b0, CRF_A_PCE, '0, rd);
        check("pc_ro", rd, pc);
        mover.move(1'b0, CRF_A_CLR, '0, rd);
        check("clr_rd", rd, '0);
        mover.move(1'b0, 5'h08, '0, rd);
        check("unmapped", rd, '0);
        // Flag set then clear, each visible one clock after the move
        d = $random(seed);
        mover.move(1'b1, CRF_A_FLG, d, rd);
        check("ifr_early", pending_interrupt_flags, '0);
        @(negedge sys_clk);
        check("ifr_set", pending_interrupt_flags, d & CRF_IRQ_MSK);
        mover.move(1'b0, CRF_A_FLG, '0, rd);
        check("ifr_rd", rd, d & CRF_IRQ_MSK);
        e = $random(seed);
        mover.move(1'b1, CRF_A_CLR, e, rd);
        check("ifr_hold", pending_interrupt_flags, d & CRF_IRQ_MSK);
        @(negedge sys_clk);
        d = d & ~e & CRF_IRQ_MSK;
        check("ifr_clr", pending_interrupt_flags, d);
        mover.move(1'b1, CRF_A_CLR, 32'h0000_0080, rd);
        repeat (2) @(negedge sys_clk);
        @(negedge sys_clk) pin[7] = 1'b1;
        @(negedge sys_clk) pin[7] = 1'b0;
        check("pin", pending_interrupt_flags, d | 32'h0000_0080);
        mover.move(1'b1, CRF_A_CSR, CRF_ONE, rd);
        pulse(take);
        check("take_gie", {31'h0, global_irq_enable}, '0);
        check("take_ifr", pending_interrupt_flags & 32'h0000_0080, '0);
        mover.move(1'b0, CRF_A_CSR, '0, rd);
        check("pgie", rd, exp_rd(CRF_A_CSR, 32'h0000_0002));
        pulse(ret_i);
        check("ret_gie", {31'h0, global_irq_enable}, CRF_ONE);
        mover.move(1'b1, CRF_A_IEN, 32'h0000_FFF0, rd);
        check("irq_req", irq_req, d & ~32'h0000_0080);
        mover.move(1'b1, CRF_A_IEN, '0, rd);
        check("irq_off", irq_req, '0);
        check("nonmaskable_irq_enable_off", {31'h0, nonmaskable_irq_enable}, '0);
        pulse(ret_n);
        check("ret_nonmaskable_irq_enable", {31'h0, nonmaskable_irq_enable}, CRF_ONE);
        @(negedge sys_clk) clipped_result_flag = 1'b1;
        fork
            @(negedge sys_clk) clipped_result_flag = 1'b0;
            mover.move(1'b0, CRF_A_CSR, '0, rd);
        join
        check("sat_early", rd & 32'h0000_0200, '0);
        mover.move(1'b0, CRF_A_CSR, '0, rd);
        check("sat_set", rd & 32'h0000_0200, 32'h0000_0200);
        mover.move(1'b1, CRF_A_CSR, '0, rd);
        mover.move(1'b0, CRF_A_CSR, '0, rd);
        check("sat_clr", rd, exp_rd(CRF_A_CSR, '0));
        report_and_stop;
    end
endmodule
